// ==== hdl/biphase_link_pkg.sv ====
// Shared constants and types for the single-wire program link
package biphase_link_pkg;

   // Clock and timing figures
   localparam int CLK_HZ         = 40_000_000;   // System clock rate
   localparam int BIT_TIME_US    = 1000;         // Nominal biphase bit time
   localparam int BIT_CYC_DEF    = (CLK_HZ / 1_000_000) * BIT_TIME_US;
   localparam int TOL_PCT        = 10;           // Receive tolerance on bit timing
   localparam int HALF_PCT       = 50;           // Mid-bit transition position
   localparam int FULL_PCT       = 100;          // Boundary transition position
   localparam int ENTRY_PULSE_US = 100;          // Least width of the entry pulse
   localparam int ENTRY_CYC      = (CLK_HZ / 1_000_000) * ENTRY_PULSE_US;

   // Widths
   localparam int CNT_W  = 17;                   // Bit-time counter, holds 110 % of a bit
   localparam int PWM_W  = 12;                   // PWM counter and duty width
   localparam int BYTE_W = 8;                    // Telegram byte width
   localparam int NB_W   = 3;                    // Bit index within a byte
   localparam int ENT_W  = 12;                   // Entry pulse counter width
   localparam int FIFO_DEPTH = 16;               // Transmit buffer words
   localparam int FIFO_AW    = 4;                // Transmit buffer address width

   // Reset values
   localparam logic LINE_RST = 1'b0;             // Pin level while in reset
   localparam logic [PWM_W-1:0] DUTY_RST = 12'h000;

   // Operating states
   typedef enum logic {MODE_APP, MODE_CFG} mode_t;
   typedef enum logic [1:0] {TX_IDLE, TX_LEAD, TX_BIT} tx_st_t;

endpackage : biphase_link_pkg

// ==== hdl/biphase_program_link.sv ====
// Output pin logic: PWM measurement output, configuration entry, biphase telegrams
// Function
// R1: In measurement state the field value is sent as PWM duty, high time over period.
// R2: New duty applies only at PWM rising edge; evaluators trigger on rising edge.
// R3: Every power-up starts in the measurement state with PWM running.
// R4: A pulse driven onto the pin by the programmer switches to configuration state.
// R5: Programmer addresses the device with serial telegrams modulated on the output line.
// R6: Device answers by modulating its own output pin; the line is half-duplex.
// R7: A zero bit has no transition inside its bit period.
// R8: A one bit has an extra transition at half the bit period.
// R9: Every bit period ends with a transition at its boundary.
// R10: Bit period about one millisecond; receivers tolerate about ten percent.
// R11: Telegrams carry memory contents, error codes and measurements both ways.
// R12: After final adjustment programmer sets write protect and clears output option bit.
// R13: Programmer reads back write protect and checks silence after power-on reset.
// R14: Programmer checks both acknowledges or the write outcome register after each store.
// R15: Two devices on one supply are reached separately through their own pins.
// R16: With write protect set the device ignores entry and telegrams, stays measuring.
`timescale 1ns/1ps
`default_nettype none
module biphase_program_link
   import biphase_link_pkg::*;
#(
   parameter int BIT_CYC = BIT_CYC_DEF           // Cycles per bit time
)(
   input  wire logic              sys_clk_i,     // System clock, 40 MHz
   input  wire logic              rst_b_i,       // Async reset, active low
   input  wire logic              clk_en_i,      // Freezes all state while low
   input  wire logic [PWM_W-1:0]  field_duty_i,  // Measured field as duty count
   input  wire logic              lock_i,        // Write-protect latch from memory
   input  wire logic              pin_i,         // Pin level as seen on the wire
   output logic                   pin_o,         // Level driven onto the pin
   output logic                   pin_oe_b_o,    // Low while the pin is driven
   input  wire logic [BYTE_W-1:0] tx_data_i,     // Reply byte
   input  wire logic              tx_valid_i,    // Reply byte offered
   output logic                   tx_ready_o,    // Reply buffer has room
   output logic [BYTE_W-1:0]      rx_data_o,     // Received telegram byte
   output logic                   rx_valid_o,    // One-cycle pulse with rx_data_o
   output logic                   rx_err_o,      // One-cycle pulse on bad timing
   output logic                   cfg_mode_o,    // High in configuration state
   output logic                   locked_o       // Write protect in force
);

   // Receive windows around the nominal transition points
   localparam logic [CNT_W-1:0] HALF_MIN = CNT_W'(BIT_CYC * (HALF_PCT - TOL_PCT) / 100);
   localparam logic [CNT_W-1:0] HALF_MAX = CNT_W'(BIT_CYC * (HALF_PCT + TOL_PCT) / 100);
   localparam logic [CNT_W-1:0] FULL_MIN = CNT_W'(BIT_CYC * (FULL_PCT - TOL_PCT) / 100);
   localparam logic [CNT_W-1:0] FULL_MAX = CNT_W'(BIT_CYC * (FULL_PCT + TOL_PCT) / 100);
   localparam logic [CNT_W-1:0] HALF_CYC = CNT_W'(BIT_CYC / 2);
   localparam logic [CNT_W-1:0] LAST_CYC = CNT_W'(BIT_CYC - 1);
   localparam logic [ENT_W-1:0] ENT_LAST = ENT_W'(ENTRY_CYC - 1);

   logic pin_meta_r, pin_sync_r, pin_prev_r;
   mode_t mode_r, mode_nxt;
   logic lock_r, lock_nxt, lock_cap_r, lock_cap_nxt;
   logic [ENT_W-1:0] ent_cnt_r, ent_cnt_nxt;
   logic [PWM_W-1:0] pwm_cnt_r, pwm_cnt_nxt, duty_r, duty_nxt;
   logic pwm_r, pwm_nxt;
   logic [CNT_W-1:0] rx_cnt_r, rx_cnt_nxt;
   logic rx_mid_r, rx_mid_nxt, rx_valid_r, rx_valid_nxt, rx_err_r, rx_err_nxt;
   logic [BYTE_W-1:0] rx_sh_r, rx_sh_nxt, rx_data_r, rx_data_nxt;
   logic [NB_W-1:0] rx_nb_r, rx_nb_nxt;
   tx_st_t tx_st_r, tx_st_nxt;
   logic [CNT_W-1:0] tx_cnt_r, tx_cnt_nxt;
   logic [BYTE_W-1:0] tx_sh_r, tx_sh_nxt;
   logic [NB_W-1:0] tx_nb_r, tx_nb_nxt;
   logic line_r, line_nxt, oe_b_r, oe_b_nxt;
   logic [BYTE_W-1:0] fifo_data;
   logic fifo_valid, fifo_pop, pin_edge, rx_on, rx_idle, bit_evt;

   // Two-stage synchroniser for the pin, then a stage for edge detection
   // Reset to the level driven in reset, so no false edge follows release
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         pin_meta_r <= LINE_RST;
         pin_sync_r <= LINE_RST;
         pin_prev_r <= LINE_RST;
      end
      else if (clk_en_i)
      begin
         pin_meta_r <= pin_i;
         pin_sync_r <= pin_meta_r;
         pin_prev_r <= pin_sync_r;
      end
   end

   assign pin_edge = pin_sync_r ^ pin_prev_r;

   // Reply bytes wait here until the line falls quiet
   sync_fifo #(
      .W     (BYTE_W),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_tx_fifo (
      .clk_i       (sys_clk_i),
      .rst_b_i     (rst_b_i),
      .en_i        (clk_en_i),
      .in_data_i   (tx_data_i),
      .in_valid_i  (tx_valid_i),
      .in_ready_o  (tx_ready_o),
      .out_data_o  (fifo_data),
      .out_valid_o (fifo_valid),
      .out_ready_i (fifo_pop)
   );

   // Mode control: lock caught one edge after reset release, entry pulse counted
   always_comb
   begin
      mode_nxt     = mode_r;
      lock_nxt     = lock_r;
      lock_cap_nxt = 1'b1;
      ent_cnt_nxt  = '0;
      if (!lock_cap_r)
         lock_nxt = lock_i;
      // Programmer overdrives the PWM level; mismatch must hold for the full width
      if (mode_r == MODE_APP && lock_cap_r && !lock_r && (pin_sync_r != line_r))     // [R4] [R16]
      begin
         ent_cnt_nxt = ent_cnt_r + 1'b1;
         if (ent_cnt_r == ENT_LAST)
         begin
            mode_nxt    = MODE_CFG;                                                  // [R4]
            ent_cnt_nxt = '0;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         mode_r     <= MODE_APP;                                                     // [R3]
         lock_r     <= 1'b0;
         lock_cap_r <= 1'b0;
         ent_cnt_r  <= '0;
      end
      else if (clk_en_i)
      begin
         mode_r     <= mode_nxt;
         lock_r     <= lock_nxt;
         lock_cap_r <= lock_cap_nxt;
         ent_cnt_r  <= ent_cnt_nxt;
      end
   end

   // PWM: duty loaded only when the period restarts, which is the rising edge
   always_comb
   begin
      pwm_cnt_nxt = pwm_cnt_r + 1'b1;
      duty_nxt    = duty_r;
      if (pwm_cnt_r == '1)
         duty_nxt = field_duty_i;                                                    // [R2]
      pwm_nxt = (pwm_cnt_nxt < duty_nxt);                                            // [R1]
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         pwm_cnt_r <= '0;
         duty_r    <= DUTY_RST;
         pwm_r     <= 1'b0;
      end
      else if (clk_en_i)
      begin
         pwm_cnt_r <= pwm_cnt_nxt;
         duty_r    <= duty_nxt;
         pwm_r     <= pwm_nxt;
      end
   end

   // Receiver listens only while the device has released the line
   assign rx_on   = (mode_r == MODE_CFG) && (tx_st_r == TX_IDLE);                    // [R6]
   assign rx_idle = (rx_cnt_r > FULL_MAX);
   assign bit_evt = rx_on && pin_edge && !rx_idle && (rx_cnt_r >= FULL_MIN);

   // Biphase decode: time every transition from the last bit boundary
   always_comb
   begin
      rx_cnt_nxt   = rx_idle ? rx_cnt_r : rx_cnt_r + 1'b1;
      rx_mid_nxt   = rx_mid_r;
      rx_sh_nxt    = rx_sh_r;
      rx_nb_nxt    = rx_nb_r;
      rx_data_nxt  = rx_data_r;
      rx_valid_nxt = 1'b0;
      rx_err_nxt   = 1'b0;
      if (!rx_on)
      begin
         rx_cnt_nxt = FULL_MAX + 1'b1;
         rx_mid_nxt = 1'b0;
         rx_nb_nxt  = '0;
      end
      else if (pin_edge)
      begin
         rx_cnt_nxt = '0;
         rx_mid_nxt = 1'b0;
         if (rx_idle)
            rx_nb_nxt = '0;                  // Leading edge only sets the time base
         else if (rx_cnt_r >= HALF_MIN && rx_cnt_r <= HALF_MAX && !rx_mid_r)        // [R10]
         begin
            rx_cnt_nxt = rx_cnt_r + 1'b1;
            rx_mid_nxt = 1'b1;                                                       // [R8]
         end
         else if (bit_evt)                                                           // [R9]
         begin
            // A mid transition marks a one, its absence a zero
            rx_sh_nxt = {rx_sh_r[BYTE_W-2:0], rx_mid_r};                             // [R7] [R8]
            rx_nb_nxt = rx_nb_r + 1'b1;
            if (rx_nb_r == '1)
            begin
               rx_data_nxt  = {rx_sh_r[BYTE_W-2:0], rx_mid_r};                       // [R11]
               rx_valid_nxt = 1'b1;
            end
         end
         else
         begin
            rx_err_nxt = 1'b1;               // Off-window edge restarts the time base
            rx_nb_nxt  = '0;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         rx_cnt_r   <= FULL_MAX + 1'b1;
         rx_mid_r   <= 1'b0;
         rx_sh_r    <= '0;
         rx_nb_r    <= '0;
         rx_data_r  <= '0;
         rx_valid_r <= 1'b0;
         rx_err_r   <= 1'b0;
      end
      else if (clk_en_i)
      begin
         rx_cnt_r   <= rx_cnt_nxt;
         rx_mid_r   <= rx_mid_nxt;
         rx_sh_r    <= rx_sh_nxt;
         rx_nb_r    <= rx_nb_nxt;
         rx_data_r  <= rx_data_nxt;
         rx_valid_r <= rx_valid_nxt;
         rx_err_r   <= rx_err_nxt;
      end
   end

   // Transmitter waits for a quiet line so replies never collide with telegrams
   assign fifo_pop = (mode_r == MODE_CFG) && (tx_st_r == TX_IDLE) && rx_idle && fifo_valid;

   always_comb
   begin
      tx_st_nxt  = tx_st_r;
      tx_cnt_nxt = tx_cnt_r + 1'b1;
      tx_sh_nxt  = tx_sh_r;
      tx_nb_nxt  = tx_nb_r;
      line_nxt   = line_r;
      oe_b_nxt   = oe_b_r;
      case (tx_st_r)
         TX_IDLE:
         begin
            tx_cnt_nxt = '0;
            if (mode_r == MODE_APP)
            begin
               line_nxt = pwm_nxt;                                                   // [R1]
               oe_b_nxt = 1'b0;
            end
            else if (fifo_pop)
            begin
               tx_sh_nxt = fifo_data;
               tx_nb_nxt = '0;
               line_nxt  = ~pin_sync_r;      // Leading edge gives the far end its time base
               oe_b_nxt  = 1'b0;                                                     // [R6]
               tx_st_nxt = TX_LEAD;
            end
            else
               oe_b_nxt = 1'b1;              // Line released for the programmer
         end
         TX_LEAD:
         begin
            // Index parked at 7 marks the tail: line released, own last edge passes the synchroniser
            if (tx_nb_r == '1)
            begin
               oe_b_nxt = 1'b1;
               if (tx_cnt_r == FULL_MAX)
                  tx_st_nxt = TX_IDLE;       // Next byte only after a full quiet span
            end
            else if (tx_cnt_r == LAST_CYC)
            begin
               tx_cnt_nxt = '0;
               tx_st_nxt  = TX_BIT;
            end
         end
         TX_BIT:
         begin
            if (tx_cnt_r == HALF_CYC && tx_sh_r[BYTE_W-1])
               line_nxt = ~line_r;                                                   // [R8]
            if (tx_cnt_r == LAST_CYC)
            begin
               line_nxt   = ~line_r;                                                 // [R7] [R9]
               tx_cnt_nxt = '0;
               tx_sh_nxt  = {tx_sh_r[BYTE_W-2:0], 1'b0};
               tx_nb_nxt  = tx_nb_r + 1'b1;
               if (tx_nb_r == '1)
               begin
                  tx_nb_nxt = tx_nb_r;       // Held at 7 so the lead state runs as tail
                  tx_st_nxt = TX_LEAD;       // Released one cycle later by the tail
               end
            end
         end
         default:
            tx_st_nxt = TX_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         tx_st_r  <= TX_IDLE;
         tx_cnt_r <= '0;
         tx_sh_r  <= '0;
         tx_nb_r  <= '0;
         line_r   <= LINE_RST;
         oe_b_r   <= 1'b0;                   // Driven from reset: measurement state owns the pin
      end
      else if (clk_en_i)
      begin
         tx_st_r  <= tx_st_nxt;
         tx_cnt_r <= tx_cnt_nxt;
         tx_sh_r  <= tx_sh_nxt;
         tx_nb_r  <= tx_nb_nxt;
         line_r   <= line_nxt;
         oe_b_r   <= oe_b_nxt;
      end
   end

   assign pin_o      = line_r;
   assign pin_oe_b_o = oe_b_r;
   assign rx_data_o  = rx_data_r;
   assign rx_valid_o = rx_valid_r;
   assign rx_err_o   = rx_err_r;
   assign cfg_mode_o = (mode_r == MODE_CFG);  // Decoded from a one-bit state flop
   assign locked_o   = lock_r;

   // Checks
   a_start_app: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)     // [R3]
      !lock_cap_r |-> mode_r == MODE_APP) else $error("not in measurement state after reset");
   a_duty_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)     // [R2]
      clk_en_i && pwm_cnt_r != '1 |=> $stable(duty_r)) else $error("duty changed mid period");
   a_pwm_level: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)     // [R1]
      mode_r == MODE_APP && $past(mode_r) == MODE_APP |-> pin_o == pwm_r && !pin_oe_b_o)
      else $error("pin does not follow pwm");
   a_lock_stays: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)    // [R16]
      lock_cap_r && lock_r |-> mode_r == MODE_APP) else $error("locked device left measurement state");
   a_entry_width: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)   // [R4]
      mode_r == MODE_APP ##1 mode_r == MODE_CFG |-> $past(ent_cnt_r) == ENT_LAST)
      else $error("entry without full pulse");
   a_cfg_release: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)   // [R6]
      clk_en_i && mode_r == MODE_CFG && tx_st_r == TX_IDLE && !fifo_pop |=> pin_oe_b_o)
      else $error("line not released");
   a_zero_quiet: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)    // [R7]
      clk_en_i && tx_st_r == TX_BIT && tx_cnt_r == HALF_CYC && !tx_sh_r[BYTE_W-1] |=> $stable(pin_o))
      else $error("zero bit has a mid transition");
   a_one_mid: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)       // [R8]
      clk_en_i && tx_st_r == TX_BIT && tx_cnt_r == HALF_CYC && tx_sh_r[BYTE_W-1] |=> pin_o != $past(pin_o))
      else $error("one bit lacks mid transition");
   a_bound_edge: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)    // [R9]
      clk_en_i && tx_st_r == TX_BIT && tx_cnt_r == LAST_CYC |=> pin_o != $past(pin_o) && !pin_oe_b_o)
      else $error("no boundary transition");
   a_rx_window: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)     // [R10]
      rx_valid_o |-> $past(rx_cnt_r) >= FULL_MIN && $past(rx_cnt_r) <= FULL_MAX)
      else $error("byte ended outside boundary window");

endmodule : biphase_program_link
`default_nettype wire

// ==== hdl/sync_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sync_fifo
   import biphase_link_pkg::*;
#(
   parameter int W     = 8,                      // Word width
   parameter int DEPTH = 16,                     // Number of words
   parameter int AW    = 4                       // Address width, log2 of DEPTH
)(
   input  wire logic         clk_i,              // Clock
   input  wire logic         rst_b_i,            // Async reset, active low
   input  wire logic         en_i,               // Clock enable
   input  wire logic [W-1:0] in_data_i,          // Write data
   input  wire logic         in_valid_i,         // Write request
   output logic              in_ready_o,         // Space available, registered
   output logic [W-1:0]      out_data_o,         // Head word
   output logic              out_valid_o,        // Head word valid
   input  wire logic         out_ready_i         // Head word taken
);

   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wr_ptr_r, wr_ptr_nxt;
   logic [AW-1:0] rd_ptr_r, rd_ptr_nxt;
   logic [AW:0]   count_r, count_nxt;
   logic          ready_r, ready_nxt;
   logic          push, pop;

   // Handshakes and pointer arithmetic
   always_comb
   begin
      push       = in_valid_i && ready_r;
      pop        = out_ready_i && (count_r != '0);
      wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
      rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
      count_nxt  = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      // Ready is registered so the source never sees a combinational path
      ready_nxt  = (count_nxt != (AW+1)'(DEPTH));
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
         ready_r  <= 1'b1;
      end
      else if (en_i)
      begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         count_r  <= count_nxt;
         ready_r  <= ready_nxt;
      end
   end

   // Storage has no reset; only written words are ever read
   always_ff @(posedge clk_i)
   begin
      if (en_i && push)
         mem[wr_ptr_r] <= in_data_i;
   end

   assign in_ready_o  = ready_r;
   assign out_data_o  = mem[rd_ptr_r];
   assign out_valid_o = (count_r != '0);

endmodule : sync_fifo
`default_nettype wire

// ==== sim/prog_model.sv ====
// Behavioural programmer standing on the sensor output line
`timescale 1ns/1ps
`default_nettype none
module prog_model #(
   parameter int BITC = 200                     // Cycles per bit time
)(
   input  wire logic clk_i,                     // Clock
   input  wire logic line_i,                    // Resolved wire level
   input  wire logic pin_o_i,                   // Device drive level
   input  wire logic oe_b_i,                    // Device enable, low drives
   output logic      frc_o,                     // Overdrive high for entry
   output logic      lvl_o                      // Level held while device is off
);
   logic [7:0] got_q[$];
   logic [7:0] sh    = 8'h00;
   logic       prev  = 1'b0;
   logic       inf   = 1'b0;
   logic       mid   = 1'b0;
   int         cnt   = 0;
   int         n     = 0;
   initial frc_o = 1'b0;
   initial lvl_o = 1'b0;
   // Decoder of replies; bit 0 starts one bit time after the leading edge
   always @(posedge clk_i)
   begin
      if (!oe_b_i && !frc_o) lvl_o <= pin_o_i;   // Keeps the level so a release makes no edge
      prev <= line_i;
      cnt  <= cnt + 1;
      if (line_i != prev)
      begin
         if (!inf)
         begin
            inf <= !oe_b_i;
            cnt <= 1 - BITC;
            mid <= 1'b0;
            n   <= 0;
         end
         else if (cnt > BITC * 4 / 10 && cnt < BITC * 6 / 10) mid <= 1'b1;
         else if (cnt > BITC * 9 / 10 && cnt < BITC * 11 / 10)
         begin
            sh  <= {sh[6:0], mid};
            mid <= 1'b0;
            cnt <= 1;
            n   <= n + 1;
            if (n == 7) got_q.push_back({sh[6:0], mid});
            if (n == 7) inf <= 1'b0;
         end
         else inf <= 1'b0;
      end
      else if (cnt > BITC * 12 / 10) inf <= 1'b0;
   end
   // One transition after c cycles
   task tgl(input int c);
      repeat (c) @(posedge clk_i);
      lvl_o <= ~lvl_o;
   endtask : tgl
   // Byte MSB first, optionally after quiet and a time-base edge
   task send_byte(input logic [7:0] b, input bit lead);
      if (lead) tgl(300);
      for (int i = 7; i >= 0; i--)
         if (b[i])
         begin
            tgl(BITC / 2);
            tgl(BITC / 2);
         end
         else tgl(BITC);
   endtask : send_byte
   // Entry pulse: overdrive the pin high for c cycles
   task entry(input int c);
      @(posedge clk_i);
      frc_o <= 1'b1;
      repeat (c) @(posedge clk_i);
      lvl_o <= 1'b1;
      frc_o <= 1'b0;
   endtask : entry
endmodule : prog_model
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench for the sensor output pin logic
`timescale 1ns/1ps
`default_nettype none
module tb
   import biphase_link_pkg::*;
;
   localparam int BC = 200;
   logic              sys_clk_i    = 1'b0;
   logic              rst_b_i      = 1'b0;
   logic              lock_i       = 1'b0;
   logic              tx_valid_i   = 1'b0;
   logic [PWM_W-1:0]  field_duty_i = 12'h000;
   logic [BYTE_W-1:0] tx_data_i    = 8'h00;
   logic              pin_o, pin_oe_b_o, tx_ready_o, rx_valid_o, rx_err_o, cfg_mode_o, locked_o;
   logic              frc, lvl, line;
   logic [BYTE_W-1:0] rx_data_o;
   logic [7:0]        rx_q[$];
   logic [7:0]        exp_rx[4]    = '{8'hA5, 8'h3C, 8'h00, 8'hFF};
   int                n_errors     = 0;
   int                n_compared   = 0;
   int                n_rxerr      = 0;
   int                i, k, h, l;
   // 40 MHz clock
   always #12.5 sys_clk_i = ~sys_clk_i;
   // The overdrive wins, else whoever has the pin enabled
   assign line = frc ? 1'b1 : (pin_oe_b_o ? lvl : pin_o);   // Own wire per device
   biphase_program_link #(.BIT_CYC(BC)) u_dut (
      .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .clk_en_i(1'b1), .field_duty_i(field_duty_i),
      .lock_i(lock_i), .pin_i(line), .pin_o(pin_o), .pin_oe_b_o(pin_oe_b_o), .tx_data_i(tx_data_i),
      .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o),
      .rx_err_o(rx_err_o), .cfg_mode_o(cfg_mode_o), .locked_o(locked_o));
   prog_model #(.BITC(BC)) u_prog (
      .clk_i(sys_clk_i), .line_i(line), .pin_o_i(pin_o), .oe_b_i(pin_oe_b_o), .frc_o(frc), .lvl_o(lvl));
   // Gathers received bytes and timing faults
   always @(posedge sys_clk_i)
   begin
      if (rx_valid_o === 1'b1) rx_q.push_back(rx_data_o);
      if (rx_err_o === 1'b1) n_rxerr++;
   end
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : chk
   task report_and_stop();
      if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : report_and_stop
   // Measures one PWM period from its rising edge; new duty offered one cycle after that edge
   task pwm_chk(input int exp, input logic [11:0] nd);
      h = 0;
      l = 0;
      for (k = 0; k < 5000 && pin_o !== 1'b1; k++) @(posedge sys_clk_i);
      field_duty_i <= nd;
      while (pin_o === 1'b1 && h < 5000)
      begin
         @(posedge sys_clk_i);
         h++;
      end
      while (pin_o !== 1'b1 && l < 5000)
      begin
         @(posedge sys_clk_i);
         l++;
      end
      chk("high time", h, exp);
      chk("period", h + l, 4096);
   endtask : pwm_chk
   // Main sequence
   initial
   begin
      repeat (4) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      chk("cfg mode", cfg_mode_o, 0);
      chk("oe_b", pin_oe_b_o, 0);
      field_duty_i <= 12'h001;
      pwm_chk(1, 12'h12C);
      pwm_chk(300, 12'hFFF);
      field_duty_i <= 12'h000;
      repeat (4200) @(posedge sys_clk_i);
      chk("idle pwm", pin_o, 0);
      u_prog.entry(3000);
      repeat (10) @(posedge sys_clk_i);
      chk("short pulse", cfg_mode_o, 0);
      u_prog.entry(4010);
      chk("cfg mode", cfg_mode_o, 1);
      chk("oe_b", pin_oe_b_o, 1);
      u_prog.send_byte(8'hA5, 1);
      u_prog.send_byte(8'h3C, 0);
      u_prog.tgl(300);
      u_prog.tgl(BC * 7 / 10);
      repeat (5) @(posedge sys_clk_i);
      chk("timing fault", n_rxerr, 1);
      u_prog.send_byte(8'h00, 1);
      u_prog.send_byte(8'hFF, 0);
      repeat (10) @(posedge sys_clk_i);
      chk("rx count", rx_q.size(), 4);
      for (i = 0; i < 4; i++) chk("rx byte", rx_q[i], exp_rx[i]);
      k = 0;
      tx_data_i  <= 8'h30;
      tx_valid_i <= 1'b1;
      for (i = 0; i < 20; i++)
      begin
         @(posedge sys_clk_i);
         if (tx_ready_o === 1'b1) k++;
         tx_data_i <= 8'(8'h30 + k);
      end
      tx_valid_i <= 1'b0;
      chk("accepted", k, FIFO_DEPTH);
      for (i = 0; i < 2500 && u_prog.got_q.size() < k; i++) repeat (20) @(posedge sys_clk_i);
      chk("reply count", u_prog.got_q.size(), k);
      for (i = 0; i < k; i++) chk("reply byte", u_prog.got_q[i], 8'(8'h30 + i));
      chk("rx while sending", rx_q.size(), 4);
      chk("fault after send", n_rxerr, 1);
      rst_b_i <= 1'b0;
      lock_i  <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      chk("locked", locked_o, 1);
      u_prog.entry(4010);
      repeat (5) @(posedge sys_clk_i);
      chk("locked cfg", cfg_mode_o, 0);
      report_and_stop();
   end
   // Watchdog, well beyond the roughly 67000 cycles the sequence needs
   initial
   begin
      repeat (100000) @(posedge sys_clk_i);
      n_errors++;
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
